// ### rtl/bsiu_pkg.sv
package bsiu_pkg;

	// ----------------------------------------
	// Register lengths
	// ----------------------------------------
	localparam int IR_LEN = 3;
	localparam int ID_LEN = 32;
	localparam int BSR_LEN = 70;

	// ----------------------------------------
	// Instruction codes
	// ----------------------------------------
	localparam logic [2:0] INSTR_EXTEST = 3'h0;
	localparam logic [2:0] INSTR_IDCODE = 3'h1;
	localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
	localparam logic [2:0] INSTR_SAMPLE = 3'h4;
	localparam logic [2:0] INSTR_BYPASS = 3'h7;

	// Pattern loaded into instruction shifter on capture
	localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
	// Bypass cell value on capture
	localparam logic BYP_CAPTURE_VAL = 1'b0;

	// ----------------------------------------
	// Identification word fields
	// ----------------------------------------
	localparam logic [3:0] ID_REVISION = 4'h0;
	localparam logic [4:0] ID_DEPTH = 5'h07;
	localparam logic [4:0] ID_WIDTH = 5'h04;
	// Arbitrary value
	localparam logic [5:0] ID_DEVICE = 6'h00;
	// Arbitrary value
	localparam logic [10:0] ID_MAKER = 11'h0155;
	localparam logic ID_PRESENT = 1'b1;
	localparam logic [31:0] ID_WORD = {ID_REVISION, ID_DEPTH, ID_WIDTH,
		ID_DEVICE, ID_MAKER, ID_PRESENT};

	// ----------------------------------------
	// Output buffer shape
	// ----------------------------------------
	localparam int OBUF_WIDTH = 2;
	localparam int OBUF_DEPTH = 32;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TDO_VALID_NS = 20;
	// Longest time, rounded down
	localparam int TDO_VALID_CYC = (TDO_VALID_NS * 1000) / CLK_PERIOD_PS;
	// Count of high mode-select edges that forces reset
	localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

	// ----------------------------------------
	// Test access port states
	// ----------------------------------------
	typedef enum logic [3:0] {
		S_RESET, S_IDLE,
		S_SEL_DR, S_CAPTURE_DR, S_SHIFT_DR, S_EXIT1_DR,
		S_PAUSE_DR, S_EXIT2_DR, S_UPDATE_DR,
		S_SEL_IR, S_CAPTURE_IR, S_SHIFT_IR, S_EXIT1_IR,
		S_PAUSE_IR, S_EXIT2_IR, S_UPDATE_IR
	} bsiu_state_e;

endpackage // bsiu_pkg

// ### rtl/bsiu_fifo.sv
`timescale 1ns/1ps

module bsiu_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	// ----------------------------------------
	// Storage and pointers
	// ----------------------------------------
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // Word storage
	logic [AW-1:0] wr_ptr; // Next slot to fill
	logic [AW-1:0] rd_ptr; // Next slot to drain
	logic [AW:0] count; // Words held
	logic push;
	logic pop;

	// Honest full and empty
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Write side
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointer bookkeeping
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + AW'(1);
			if (pop)
				rd_ptr <= rd_ptr + AW'(1);
			if (push && !pop)
				count <= count + (AW+1)'(1);
			else if (pop && !push)
				count <= count - (AW+1)'(1);
		end
	end

endmodule // bsiu_fifo

// ### rtl/bsiu_tap_unit.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Code 000 captures pin ring like sample
// - Code 000 floats memory data outputs
// - Identification code loads fixed 32-bit word
// - Reset and power-up select identification code
// - Code 010 captures ring, shifts boundary register
// - Code 010 floats memory outputs
// - Sample latches pin snapshot at capture
// - Boundary data never drives memory pins
// - Update-DR under sample does nothing
// - Shift-DR after capture shifts boundary register
// - Bypass routes input through one cell
// - Identification leaves memory traffic undisturbed
// - Seventy cells, address LSBs last
// - Capture-IR loads low bits with 01
// - Instruction takes effect at Update-IR
// - Sample on rise, drive on fall
// - Five high mode edges reset logic

module bsiu_tap_unit
	import bsiu_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic [BSR_LEN-1:0] pin_ring,
	output logic tdo,
	output logic tdo_oe,
	output logic mem_out_hiz
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int TDO_LAT = TDO_VALID_CYC; // Fall edge to serial output, cycles
	logic [2:0] pin_s1; // First stage, test pins
	logic [2:0] pin_s2; // Second stage, test pins
	logic tck_prev; // Last synced test clock
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic rise; // Test clock rising edge
	logic fall; // Test clock falling edge
	logic [BSR_LEN-1:0] ring_s1; // First stage, pin ring
	logic [BSR_LEN-1:0] ring_s2; // Second stage, pin ring
	bsiu_state_e state; // Port state
	bsiu_state_e next_state;
	logic [IR_LEN-1:0] ir_sh; // Instruction shifter
	logic [IR_LEN-1:0] ir; // Active instruction
	logic [ID_LEN-1:0] id_sh; // Identification shifter
	logic byp; // Bypass cell
	logic [BSR_LEN-1:0] bsr; // Boundary shifter
	logic shifting; // In a shift state
	logic ser_bit; // Bit presented to the output
	logic obuf_ready;
	logic obuf_valid;
	logic [OBUF_WIDTH-1:0] obuf_data;
	logic [2:0] tms_run; // Consecutive high mode edges
	default clocking dclk @(posedge clk); endclocking // Checks run on the system clock
	default disable iff (!rst_b);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Instructions routing the boundary register
	function automatic logic uses_bsr(input logic [IR_LEN-1:0] code);
		uses_bsr = (code == INSTR_EXTEST) || (code == INSTR_SAMPLE_Z) ||
			(code == INSTR_SAMPLE);
	endfunction

	// Instructions that float memory outputs
	function automatic logic floats_mem(input logic [IR_LEN-1:0] code);
		floats_mem = (code == INSTR_EXTEST) || (code == INSTR_SAMPLE_Z);
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Test pins through two flops
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
		end
		else
		begin
			pin_s1 <= {tck, tms, tdi};
			pin_s2 <= pin_s1;
		end
	end

	assign tck_s = pin_s2[2];
	assign tms_s = pin_s2[1];
	assign tdi_s = pin_s2[0];

	// Pin ring through two flops
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ring_s1 <= '0;
			ring_s2 <= '0;
		end
		else
		begin
			ring_s1 <= pin_ring;
			ring_s2 <= ring_s1;
		end
	end

	// Edge finder on the synced test clock
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			tck_prev <= 1'b0;
		else
			tck_prev <= tck_s;
	end

	assign rise = tck_s && !tck_prev;
	assign fall = !tck_s && tck_prev;

	// ----------------------------------------
	// Port state machine
	// ----------------------------------------
	// Next state from mode select
	always_comb
	begin
		case (state)
			S_RESET: next_state = tms_s ? S_RESET : S_IDLE;
			S_IDLE: next_state = tms_s ? S_SEL_DR : S_IDLE;
			S_SEL_DR: next_state = tms_s ? S_SEL_IR : S_CAPTURE_DR;
			S_CAPTURE_DR: next_state = tms_s ? S_EXIT1_DR : S_SHIFT_DR;
			S_SHIFT_DR: next_state = tms_s ? S_EXIT1_DR : S_SHIFT_DR;
			S_EXIT1_DR: next_state = tms_s ? S_UPDATE_DR : S_PAUSE_DR;
			S_PAUSE_DR: next_state = tms_s ? S_EXIT2_DR : S_PAUSE_DR;
			S_EXIT2_DR: next_state = tms_s ? S_UPDATE_DR : S_SHIFT_DR;
			S_UPDATE_DR: next_state = tms_s ? S_SEL_DR : S_IDLE;
			S_SEL_IR: next_state = tms_s ? S_RESET : S_CAPTURE_IR;
			S_CAPTURE_IR: next_state = tms_s ? S_EXIT1_IR : S_SHIFT_IR;
			S_SHIFT_IR: next_state = tms_s ? S_EXIT1_IR : S_SHIFT_IR;
			S_EXIT1_IR: next_state = tms_s ? S_UPDATE_IR : S_PAUSE_IR;
			S_PAUSE_IR: next_state = tms_s ? S_EXIT2_IR : S_PAUSE_IR;
			S_EXIT2_IR: next_state = tms_s ? S_UPDATE_IR : S_SHIFT_IR;
			S_UPDATE_IR: next_state = tms_s ? S_SEL_DR : S_IDLE;
			default: next_state = S_RESET;
		endcase
	end

	// Advance on each rising test clock edge
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state <= S_RESET;
		else if (rise)
			state <= next_state;
	end

	// ----------------------------------------
	// Instruction register
	// ----------------------------------------
	// Capture and shift the instruction shifter
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ir_sh <= INSTR_IDCODE;
		else if (rise)
		begin
			if (state == S_CAPTURE_IR)
				ir_sh <= IR_CAPTURE_VAL;
			else if (state == S_SHIFT_IR)
				ir_sh <= {tdi_s, ir_sh[IR_LEN-1:1]};
		end
	end

	// Active instruction, changed only at update or reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ir <= INSTR_IDCODE;
		else if (rise)
		begin
			if (next_state == S_RESET)
				ir <= INSTR_IDCODE;
			else if (next_state == S_UPDATE_IR)
				ir <= ir_sh;
		end
	end

	// ----------------------------------------
	// Data registers
	// ----------------------------------------
	// Identification shifter
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			id_sh <= '0;
		else if (rise && ir == INSTR_IDCODE)
		begin
			if (state == S_CAPTURE_DR)
				id_sh <= ID_WORD;
			else if (state == S_SHIFT_DR)
				id_sh <= {tdi_s, id_sh[ID_LEN-1:1]};
		end
	end

	// Bypass cell, also taken by reserved codes
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			byp <= 1'b0;
		else if (rise && ir != INSTR_IDCODE && !uses_bsr(ir))
		begin
			if (state == S_CAPTURE_DR)
				byp <= BYP_CAPTURE_VAL;
			else if (state == S_SHIFT_DR)
				byp <= tdi_s;
		end
	end

	// Boundary shifter; cell n sits at index n-1, nothing drives pins
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			bsr <= '0;
		else if (rise && uses_bsr(ir))
		begin
			if (state == S_CAPTURE_DR)
				bsr <= ring_s2;
			else if (state == S_SHIFT_DR)
				bsr <= {tdi_s, bsr[BSR_LEN-1:1]};
			// Update-DR leaves the cells alone
		end
	end

	// ----------------------------------------
	// Serial output path
	// ----------------------------------------
	assign shifting = (state == S_SHIFT_DR) || (state == S_SHIFT_IR);

	// Select the low bit of the routed register
	always_comb
	begin
		if (state == S_SHIFT_IR)
			ser_bit = ir_sh[0];
		else if (ir == INSTR_IDCODE)
			ser_bit = id_sh[0];
		else if (uses_bsr(ir))
			ser_bit = bsr[0];
		else
			ser_bit = byp;
	end

	// Output buffer, filled on each falling test clock edge
	bsiu_fifo #(
		.WIDTH(OBUF_WIDTH),
		.DEPTH(OBUF_DEPTH)
	) u_obuf (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(fall),
		.in_ready(obuf_ready),
		.in_data({shifting, ser_bit}),
		.out_valid(obuf_valid),
		.out_ready(1'b1),
		.out_data(obuf_data)
	);

	// Drive pin registers from the buffer; floated after reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end
		else if (obuf_valid)
		begin
			tdo <= obuf_data[0];
			tdo_oe <= obuf_data[1];
		end
	end

	// ----------------------------------------
	// Memory output float control
	// ----------------------------------------
	// High while an external-test or floating-sample code is active
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			mem_out_hiz <= 1'b0;
		else
			mem_out_hiz <= floats_mem(ir);
	end

	// ----------------------------------------
	// Checking helpers and assertions
	// ----------------------------------------
	// Runs of high mode-select at rising edges, saturating
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			tms_run <= 3'h0;
		else if (rise)
		begin
			if (!tms_s)
				tms_run <= 3'h0;
			else if (tms_run != TMS_RESET_EDGES)
				tms_run <= tms_run + 3'h1;
		end
	end
	a_ir_reset_load: assert property (
		(rise && next_state == S_RESET) |=> (ir == INSTR_IDCODE))
		else $error("Reset did not select identification");
	a_ir_capture_pat: assert property (
		(rise && state == S_CAPTURE_IR) |=> (ir_sh[1:0] == 2'b01))
		else $error("Instruction capture pattern wrong");
	a_ir_update_only: assert property (
		!(rise && (next_state == S_UPDATE_IR || next_state == S_RESET))
		|=> $stable(ir))
		else $error("Instruction changed outside update");
	a_ext_float: assert property (
		(ir == INSTR_EXTEST) [*2] |-> mem_out_hiz)
		else $error("External test left outputs driven");
	a_samz_float: assert property (
		(ir == INSTR_SAMPLE_Z) [*2] |-> mem_out_hiz)
		else $error("Floating sample left outputs driven");
	a_mem_undisturbed: assert property (
		(ir == INSTR_IDCODE || ir == INSTR_SAMPLE || ir == INSTR_BYPASS) [*2]
		|-> !mem_out_hiz)
		else $error("Memory outputs floated wrongly");
	a_id_capture: assert property (
		(rise && state == S_CAPTURE_DR && ir == INSTR_IDCODE) |=> (id_sh == ID_WORD))
		else $error("Identification word not loaded");
	a_bsr_capture: assert property (
		(rise && state == S_CAPTURE_DR && uses_bsr(ir)) |=> (bsr == $past(ring_s2)))
		else $error("Pin ring not captured");
	a_update_noop: assert property (
		(rise && state == S_UPDATE_DR) |=> $stable(bsr))
		else $error("Update changed boundary cells");
	a_bypass_path: assert property (
		(rise && state == S_SHIFT_DR && ir == INSTR_BYPASS) |=> (byp == $past(tdi_s)))
		else $error("Bypass cell did not take input");
	a_five_high: assert property (
		(tms_run == TMS_RESET_EDGES) |-> (state == S_RESET))
		else $error("Five high edges did not reset");
	a_obuf_room: assert property (
		fall |-> obuf_ready)
		else $error("Output buffer full at a falling edge");
	a_out_float: assert property (
		(fall && !shifting) |-> ##[2:TDO_LAT] !tdo_oe)
		else $error("Serial output enabled outside shift");
	a_out_enable: assert property (
		(fall && shifting) |-> ##2 (tdo_oe && tdo == $past(ser_bit, 2)))
		else $error("Serial output not enabled in shift");

endmodule // bsiu_tap_unit

// ### testbench/bsiu_ctl_model.sv
`timescale 1ns/1ps

module bsiu_ctl_model
	import bsiu_pkg::*;
#(
	parameter int HALF_CYC = 10
)
(
	input wire logic clk,
	input wire logic tdo,
	input wire logic tdo_oe,
	output logic tck,
	output logic tms,
	output logic tdi
);

	// --------------------
	// Test port driver
	// --------------------
	// Clock parked low, mode and data at pull-up level
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One period: fall with new levels, sample output late in low half, then rise
	task automatic step(input logic m, input logic d, output logic q, output logic oe);
	begin
		@(posedge clk);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (HALF_CYC - 1) @(posedge clk);
		q = tdo_oe ? tdo : !tdo; // Released line reads as the inverse
		oe = tdo_oe;
		@(posedge clk);
		tck <= 1'b1;
		repeat (HALF_CYC - 1) @(posedge clk);
	end
	endtask

	// Park the clock low before a system reset
	task automatic park();
	begin
		@(posedge clk);
		tck <= 1'b0;
	end
	endtask

	// Shift a run of bits, leaving the shift state on the last one
	task automatic scan(input int n, input logic [BSR_LEN-1:0] din,
		output logic [BSR_LEN-1:0] dout, output int oe_cnt);
		logic q;
		logic oe;
	begin
		dout = '0;
		oe_cnt = 0;
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q, oe);
			dout[i] = q;
			if (oe === 1'b1)
				oe_cnt++;
		end
	end
	endtask

endmodule // bsiu_ctl_model

// ### testbench/bsiu_tap_unit_tb.sv
`timescale 1ns/1ps

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
	$display("mismatch at %0t: got %h exp %h", $time, (a), (b)); fails++; end end

module bsiu_tap_unit_tb
	import bsiu_pkg::*;
;
	logic clk; // System clock
	logic rst_b; // Async reset, active low
	logic [BSR_LEN-1:0] pin_ring; // Memory pin levels
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	logic mem_out_hiz;
	int fails;
	int tests_run;
	int cycles; // Hang guard

	bsiu_tap_unit DUT (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
		.pin_ring(pin_ring), .tdo(tdo), .tdo_oe(tdo_oe), .mem_out_hiz(mem_out_hiz));

	bsiu_ctl_model u_ctl (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
		.tdi(tdi));

	// --------------------
	// Clock and guard
	// --------------------
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Cut a hang short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fails++;
			test_done();
		end
	end

	task automatic test_done();
	begin
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	// --------------------
	// Navigation
	// --------------------
	// One test clock with data at idle level
	task automatic go(input logic m);
		logic q;
		logic oe;
	begin
		u_ctl.step(m, 1'b1, q, oe);
	end
	endtask

	// Idle to Shift-IR, shift code, update, back to Idle
	task automatic load_ir(input logic [2:0] code);
		logic [BSR_LEN-1:0] d;
		logic hiz0;
		int k;
	begin
		hiz0 = mem_out_hiz;
		go(1'b1);
		go(1'b1);
		go(1'b0);
		go(1'b0);
		u_ctl.scan(IR_LEN, BSR_LEN'(code), d, k);
		`CHK(d[2:0], IR_CAPTURE_VAL)
		`CHK(k, IR_LEN)
		`CHK(mem_out_hiz, hiz0)
		go(1'b1);
		go(1'b0);
		`CHK(mem_out_hiz, (code == INSTR_EXTEST) || (code == INSTR_SAMPLE_Z))
	end
	endtask

	// Idle to capture, shift n bits, update, back to Idle
	task automatic scan_dr(input int n, input logic [BSR_LEN-1:0] din,
		output logic [BSR_LEN-1:0] dout);
		int k;
	begin
		go(1'b1);
		go(1'b0);
		go(1'b0);
		u_ctl.scan(n, din, dout, k);
		`CHK(k, n)
		go(1'b1);
		go(1'b0);
		`CHK(tdo_oe, 1'b0)
	end
	endtask

	// --------------------
	// Scenarios
	// --------------------
	// Identification word straight after reset
	task automatic t_id();
		logic [BSR_LEN-1:0] d;
	begin
		`CHK(tdo_oe, 1'b0)
		go(1'b0);
		scan_dr(ID_LEN, '1, d);
		`CHK(d[31:0], ID_WORD)
	end
	endtask

	// Ring capture, shift-in ignored, second capture sees new ring
	task automatic t_boundary(input logic [2:0] code, input logic [BSR_LEN-1:0] ring);
		logic [BSR_LEN-1:0] d;
		logic [BSR_LEN-1:0] rot;
	begin
		rot = {ring[0], ring[BSR_LEN-1:1]};
		load_ir(code);
		@(posedge clk);
		pin_ring <= ring;
		scan_dr(BSR_LEN, ~ring, d);
		`CHK(d, ring)
		@(posedge clk);
		pin_ring <= rot;
		scan_dr(BSR_LEN, ring, d);
		`CHK(d, rot)
		`CHK(mem_out_hiz, code != INSTR_SAMPLE)
	end
	endtask

	// One-cell path, cleared at capture
	task automatic t_bypass();
		logic [BSR_LEN-1:0] din;
		logic [BSR_LEN-1:0] d;
	begin
		din = BSR_LEN'(8'hb5);
		load_ir(INSTR_BYPASS);
		scan_dr(8, din, d);
		`CHK(d[7:0], {din[6:0], BYP_CAPTURE_VAL})
	end
	endtask

	// Mode-select reset, then system reset in mid-run
	task automatic t_resets();
		logic [BSR_LEN-1:0] d;
	begin
		load_ir(INSTR_EXTEST);
		repeat (5) go(1'b1);
		`CHK(mem_out_hiz, 1'b0)
		go(1'b0);
		scan_dr(ID_LEN, '0, d);
		`CHK(d[31:0], ID_WORD)
		load_ir(INSTR_SAMPLE_Z);
		u_ctl.park();
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(mem_out_hiz, 1'b0)
		`CHK(tdo_oe, 1'b0)
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		t_id();
	end
	endtask

	// --------------------
	// Main sequence
	// --------------------
	// Reserved codes never loaded
	initial
	begin
		rst_b = 1'b0;
		pin_ring = '0;
		fails = 0;
		tests_run = 0;
		cycles = 0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		t_id();
		t_boundary(INSTR_EXTEST, 70'h2a_5c3e_9b71_d046_8f13);
		t_boundary(INSTR_SAMPLE_Z, 70'h1_9e07_c4a2_63bd_58f6);
		t_boundary(INSTR_SAMPLE, 70'h3f_0c1d_a7e2_4b95_6368);
		t_bypass();
		t_resets();
		test_done();
	end

endmodule // bsiu_tap_unit_tb
